// [logic/cssc_pkg.sv]
// Constants and types of the capacitive-sense scan and compare controller
// Operation
// - Mask method steps only to enabled mask channels
// - Start channel shares mux select encoding
// - Mode 101b mask scan stops on touch
// - Busy write resumes after stopped channel
// - Mask scan stops after all channels clean
// - Clean scan end wakes if wake enabled
// - Flag cleared if result <= threshold, else set
// - Compare only after last accumulated conversion
// - Greater-than interrupt when flag set, enabled
// - Flag set halts scan until busy write
// - Greater-than event wakes regardless of enable
// - Accumulate 1..64 samples, divide, store result
// - Compare averaged value; stop scan on event
// - Touch holds mux, else increment and wrap
// - Watched output change repeats conversion portion
// - Serial peripheral watch enable resets to zero
// - Retry limit: unlimited, two or four
// - Retry event flag sticky until cleared
// - Slow-clock wake with watch restarts conversion
// - Contiguous scan advances to end, wraps start
package cssc_pkg;
  localparam int CH_W = 6;
  localparam int NCH = 64;
  localparam logic [CH_W-1:0] CH_ONE = 6'h01;
  // Start modes
  localparam logic [2:0] CM_CONT_SCAN = 3'h7;
  localparam logic [2:0] CM_MASK_SCAN = 3'h5;
  localparam logic [2:0] CM_CONT_ONE = 3'h6;
  // Retry limit codes
  localparam logic [1:0] RL_ALL = 2'h0;
  localparam logic [1:0] RL_TWO = 2'h1;
  localparam logic [3:0] RL_TWO_N = 4'h2;
  localparam logic [3:0] RL_FOUR_N = 4'h4;
  localparam logic [6:0] ONE_SAMPLE = 7'h01;
  // Clock rate and wake restart threshold in kHz
  localparam int CLK_KHZ = 50000;
  localparam int SLOW_KHZ = 1800;
  localparam logic [15:0] SLOW_KHZ_W = 16'(SLOW_KHZ);

  typedef struct packed {
    logic       scan_method_select;
    logic [2:0] conversion_start_mode;
    logic [2:0] accumulate_count_select;
    logic       end_of_scan_wake_enable;
    logic       greater_than_irq_enable;
    logic [15:0] threshold;
    logic [CH_W-1:0] scan_start_channel;
    logic [CH_W-1:0] scan_end_channel;
  } cssc_cfg_t;

  typedef struct packed {
    logic smbus_watch_enable;
    logic port_write_watch_enable;
    logic spi_watch_enable;
    logic [1:0] retry_limit_select;
  } cssc_watch_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_NEXT} cssc_state_t;
endpackage : cssc_pkg

// [logic/cssc_ctrl.sv]
// Scan sequencer, accumulator, comparator and pin watch of the sense block
`timescale 1ns/1ps
`default_nettype none
module cssc_ctrl
  import cssc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire cssc_cfg_t          cfg,
  input  wire cssc_watch_t        watch,
  input  wire logic [NCH-1:0]     channel_scan_mask,
  input  wire logic [15:0]        active_clk_khz,
  input  wire logic               busy_write,
  input  wire logic               start_write,
  input  wire logic               flag_clear,
  input  wire logic               retry_clear,
  input  wire logic               wake_restart,
  input  wire logic [2:0]         out_change_async,
  input  wire logic               conv_done,
  input  wire logic [15:0]        conv_value,
  output logic                    conv_start,
  output logic                    conv_repeat,
  output logic [CH_W-1:0]         channel_mux_select,
  output logic                    conversion_busy_bit,
  output logic                    threshold_compare_flag,
  output logic                    conversion_done_flag,
  output logic                    gt_irq,
  output logic                    wake_event,
  output logic                    retry_event_flag,
  output logic [15:0]             result
);
  // All checks below run on the system clock and rest during reset
  default clocking cssc_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Sample count for accumulate code
  function automatic logic [6:0] acc_count(input logic [2:0] s);
    unique case (s)
      3'h0:    acc_count = 7'h01;
      3'h1:    acc_count = 7'h04;
      3'h2:    acc_count = 7'h08;
      3'h3:    acc_count = 7'h10;
      3'h4:    acc_count = 7'h20;
      default: acc_count = 7'h40;
    endcase
  endfunction : acc_count

  // Divide shift for accumulate code
  function automatic logic [2:0] acc_shift(input logic [2:0] s);
    unique case (s)
      3'h0:    acc_shift = 3'h0;
      3'h1:    acc_shift = 3'h2;
      3'h2:    acc_shift = 3'h3;
      3'h3:    acc_shift = 3'h4;
      3'h4:    acc_shift = 3'h5;
      default: acc_shift = 3'h6;
    endcase
  endfunction : acc_shift

  // Output change pins cross from foreign domains
  logic [2:0] chg_s1_ff;
  logic [2:0] chg_s2_ff;
  // Watch enables held locally so each one reads zero out of reset
  logic [2:0] wen_ff;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chg_s1_ff <= 3'h0;
      chg_s2_ff <= 3'h0;
      wen_ff    <= 3'h0;
    end else begin
      chg_s1_ff <= out_change_async;
      chg_s2_ff <= chg_s1_ff;
      wen_ff    <= {watch.smbus_watch_enable,
                    watch.port_write_watch_enable, watch.spi_watch_enable};
    end
  end

  cssc_state_t     state_ff, nxt_state;
  logic [CH_W-1:0] mux_ff, nxt_mux;
  logic            busy_ff, nxt_busy;
  logic            cmpf_ff, nxt_cmpf;
  logic            done_ff, nxt_done;
  logic            irq_ff, nxt_irq;
  logic            wake_ff, nxt_wake;
  logic            pme_ff, nxt_pme;
  logic            start_ff, nxt_start;
  logic            rep_ff, nxt_rep;
  logic [21:0]     sum_ff, nxt_sum;
  logic [6:0]      cnt_ff, nxt_cnt;
  logic [2:0]      tries_ff, nxt_tries;
  logic [15:0]     res_ff, nxt_res;

  logic            auto_scan;
  logic            mask_scan;
  logic            hit;
  logic            allow_retry;
  logic [21:0]     sum_new;
  logic [15:0]     avg;
  logic [CH_W-1:0] next_ch;
  logic            wrapped;
  logic            slow_wake;

  // Pick next enabled mask channel after the current one
  always_comb begin
    next_ch = mux_ff;
    wrapped = 1'b1;
    for (int i = NCH - 1; i >= 1; i--) begin
      if (channel_scan_mask[CH_W'(32'(mux_ff) + i)] &&
          (32'(mux_ff) + i < NCH)) begin
        next_ch = CH_W'(32'(mux_ff) + i);
        wrapped = 1'b0;
      end
    end
  end

  // Sequencer, accumulator and comparator next state
  always_comb begin
    auto_scan = (cfg.conversion_start_mode == CM_CONT_SCAN) ||
                (cfg.scan_method_select &&
                 cfg.conversion_start_mode == CM_MASK_SCAN);
    mask_scan = cfg.scan_method_select;
    sum_new = sum_ff + {6'h0, conv_value};
    avg = 16'(sum_new >> acc_shift(cfg.accumulate_count_select));
    hit = avg > cfg.threshold;
    // Retries capped by limit code; reset code allows all
    unique case (watch.retry_limit_select)
      RL_ALL:  allow_retry = 1'b1;
      RL_TWO:  allow_retry = {1'b0, tries_ff} < RL_TWO_N;
      default: allow_retry = {1'b0, tries_ff} < RL_FOUR_N;
    endcase
    slow_wake = wake_restart && (active_clk_khz < SLOW_KHZ_W) &&
                (|wen_ff);
    nxt_state = state_ff;
    nxt_mux   = mux_ff;
    nxt_busy  = busy_ff;
    nxt_cmpf  = cmpf_ff;
    nxt_done  = done_ff && !flag_clear;
    nxt_irq   = 1'b0;
    nxt_wake  = 1'b0;
    nxt_pme   = pme_ff && !retry_clear;
    nxt_start = 1'b0;
    nxt_rep   = 1'b0;
    nxt_sum   = sum_ff;
    nxt_cnt   = cnt_ff;
    nxt_tries = tries_ff;
    nxt_res   = res_ff;
    if (flag_clear)
      nxt_cmpf = 1'b0;
    // Start channel write copies into mux, same encoding
    if (start_write && auto_scan)
      nxt_mux = cfg.scan_start_channel;
    unique case (state_ff)
      ST_IDLE: begin
        // Busy write resumes at the channel after the stop point
        if (busy_write || slow_wake) begin
          nxt_busy  = 1'b1;
          nxt_cmpf  = 1'b0;
          nxt_sum   = '0;
          nxt_cnt   = '0;
          nxt_tries = '0;
          nxt_start = 1'b1;
          nxt_state = ST_CONV;
          if (auto_scan && cmpf_ff) begin
            nxt_mux = mask_scan ? next_ch : mux_ff + CH_ONE;
            if (!mask_scan && mux_ff == cfg.scan_end_channel)
              nxt_mux = cfg.scan_start_channel;
          end
        end
      end
      ST_CONV: begin
        // Watched output change repeats the current portion
        if ((|(chg_s2_ff & wen_ff)) && allow_retry) begin
          nxt_rep   = 1'b1;
          nxt_pme   = 1'b1;
          nxt_tries = tries_ff + 3'h1;
        end else if (conv_done) begin
          nxt_sum = sum_new;
          nxt_cnt = cnt_ff + ONE_SAMPLE;
          nxt_tries = '0;
          if (cnt_ff + ONE_SAMPLE < acc_count(cfg.accumulate_count_select))
            nxt_start = 1'b1;
          else begin
            nxt_res  = avg;
            nxt_done = 1'b1;
            nxt_cmpf = hit;
            nxt_irq  = hit && cfg.greater_than_irq_enable;
            nxt_wake = hit;
            nxt_state = ST_NEXT;
          end
        end
      end
      default: begin
        nxt_sum = '0;
        nxt_cnt = '0;
        nxt_state = ST_IDLE;
        if (cmpf_ff || !auto_scan) begin
          nxt_busy = 1'b0;
        end else if (mask_scan) begin
          if (wrapped) begin
            nxt_busy = 1'b0;
            nxt_wake = cfg.end_of_scan_wake_enable;
          end else begin
            nxt_mux = next_ch;
            nxt_start = 1'b1;
            nxt_state = ST_CONV;
          end
        end else begin
          // Contiguous scan: advance then wrap after end
          nxt_mux = (mux_ff == cfg.scan_end_channel) ?
                    cfg.scan_start_channel : mux_ff + CH_ONE;
          nxt_start = 1'b1;
          nxt_state = ST_CONV;
        end
      end
    endcase
  end

  // Register all sequencer state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      mux_ff   <= '0;
      busy_ff  <= 1'b0;
      cmpf_ff  <= 1'b0;
      done_ff  <= 1'b0;
      irq_ff   <= 1'b0;
      wake_ff  <= 1'b0;
      pme_ff   <= 1'b0;
      start_ff <= 1'b0;
      rep_ff   <= 1'b0;
      sum_ff   <= '0;
      cnt_ff   <= '0;
      tries_ff <= '0;
      res_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      mux_ff   <= nxt_mux;
      busy_ff  <= nxt_busy;
      cmpf_ff  <= nxt_cmpf;
      done_ff  <= nxt_done;
      irq_ff   <= nxt_irq;
      wake_ff  <= nxt_wake;
      pme_ff   <= nxt_pme;
      start_ff <= nxt_start;
      rep_ff   <= nxt_rep;
      sum_ff   <= nxt_sum;
      cnt_ff   <= nxt_cnt;
      tries_ff <= nxt_tries;
      res_ff   <= nxt_res;
    end
  end

  assign conv_start             = start_ff;
  assign conv_repeat            = rep_ff;
  assign channel_mux_select     = mux_ff;
  assign conversion_busy_bit    = busy_ff;
  assign threshold_compare_flag = cmpf_ff;
  assign conversion_done_flag   = done_ff;
  assign gt_irq                 = irq_ff;
  assign wake_event             = wake_ff;
  assign retry_event_flag       = pme_ff;
  assign result                 = res_ff;

  // Compare result reaches flag one cycle after last sample
  sequence s_last_done;
    state_ff == ST_CONV && conv_done && !nxt_rep &&
    cnt_ff + ONE_SAMPLE >= acc_count(cfg.accumulate_count_select);
  endsequence
  a_flag_sets_hit: assert property (s_last_done ##0 hit |=> cmpf_ff)
    else $error("flag not set on result above threshold");
  a_flag_clr_low: assert property (s_last_done ##0 !hit |=> !cmpf_ff)
    else $error("flag set on result not above threshold");
  a_irq_gated: assert property (gt_irq |->
    cmpf_ff && cfg.greater_than_irq_enable && done_ff)
    else $error("irq without flag and enable");
  a_irq_on_hit: assert property (s_last_done ##0
    hit && cfg.greater_than_irq_enable |=> gt_irq)
    else $error("no irq on enabled greater-than event");
  a_wake_on_hit: assert property (s_last_done ##0 hit |=> wake_event)
    else $error("no wake on greater-than event");
  a_halt_on_hit: assert property (s_last_done ##0 hit |=>
    ##1 (!busy_ff && $stable(mux_ff)))
    else $error("scan kept running after touch");
  a_hold_idle: assert property (state_ff == ST_IDLE &&
    !busy_write && !slow_wake |=> !conv_start)
    else $error("conversion started while halted");
  a_retry_sticky: assert property (retry_event_flag &&
    !retry_clear |=> retry_event_flag)
    else $error("retry flag dropped without clear");
  a_retry_mark: assert property (conv_repeat |-> retry_event_flag)
    else $error("retry without event flag");
  a_contig_wrap: assert property (state_ff == ST_NEXT && !cmpf_ff &&
    auto_scan && !mask_scan && mux_ff == cfg.scan_end_channel |=>
    mux_ff == $past(cfg.scan_start_channel))
    else $error("mux did not wrap to start channel");
  a_accum_count: assert property (conv_done && state_ff == ST_CONV &&
    !nxt_rep &&
    cnt_ff + ONE_SAMPLE < acc_count(cfg.accumulate_count_select) |=>
    conv_start && $stable(cmpf_ff) && $stable(result) && !gt_irq)
    else $error("compare made before last sample");
  // Mask scan step after a clean result
  sequence s_mask_step;
    state_ff == ST_NEXT && !cmpf_ff && auto_scan && mask_scan;
  endsequence
  a_mask_next_en: assert property (s_mask_step ##0 !wrapped |=>
    channel_scan_mask[mux_ff])
    else $error("mask scan moved to a disabled channel");
  a_mask_end_wake: assert property (s_mask_step ##0 wrapped |=>
    !busy_ff && wake_event == $past(cfg.end_of_scan_wake_enable))
    else $error("mask scan did not stop cleanly at its end");
  a_start_copy: assert property (start_write && auto_scan &&
    state_ff == ST_IDLE && !busy_write && !slow_wake |=>
    mux_ff == $past(cfg.scan_start_channel))
    else $error("start channel not copied to mux");
  a_busy_stop: assert property (state_ff == ST_NEXT &&
    (cmpf_ff || !auto_scan) |=> !busy_ff)
    else $error("busy held after sequence stopped");
  a_watch_rst: assert property ($past(sys_rst) |-> wen_ff == 3'h0)
    else $error("watch enables not cleared by reset");
endmodule : cssc_ctrl
`default_nettype wire

// [tb/cssc_conv_model.sv]
// Behavioural model of the analog converter behind the sense multiplexer
`timescale 1ns/1ps
`default_nettype none
module cssc_conv_model
  import cssc_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 conv_start,
  input  wire logic                 conv_repeat,
  input  wire logic                 slow,
  input  wire logic [CH_W-1:0]      channel_mux_select,
  input  wire logic [NCH-1:0][15:0] chan_val,
  output logic                      conv_done,
  output logic [15:0]               conv_value
);
  int cnt_ff;

  // Countdown per conversion; a repeat restarts the charge cycle.
  // Outside the done cycle the sample toggles so stale data never matches.
  always_ff @(posedge clock) begin
    conv_done  <= 1'b0;
    conv_value <= ~conv_value;
    if (sys_rst) begin
      cnt_ff     <= 0;
      conv_value <= 16'h0;
    end else if (conv_start || conv_repeat) begin
      cnt_ff <= slow ? 9 : 2;
    end else if (cnt_ff == 1) begin
      cnt_ff     <= 0;
      conv_done  <= 1'b1;
      conv_value <= chan_val[channel_mux_select];
    end else if (cnt_ff > 1) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : cssc_conv_model
`default_nettype wire

// [tb/cssc_ctrl_tb.sv]
// Self-checking bench of the scan and compare controller
`timescale 1ns/1ps
`default_nettype none
module cssc_ctrl_tb
  import cssc_pkg::*;
;
  typedef struct {
    logic [15:0]     res;
    logic            flag;
    logic [CH_W-1:0] mux;
    bit              mchk;
  } cssc_note_t;
  cssc_note_t            notes[$];
  cssc_note_t            e;
  cssc_cfg_t             cfg;
  cssc_watch_t           watch;
  logic [NCH-1:0][15:0]  vals;
  logic [NCH-1:0]        channel_scan_mask;
  logic [15:0]           active_clk_khz, conv_value, result;
  logic [2:0]            out_change_async;
  logic [CH_W-1:0]       mux;
  logic clock, sys_rst, busy_write, start_write, flag_clear, retry_clear;
  logic wake_restart, conv_done, conv_start, conv_repeat, busy, cmp_flag;
  logic done_flag, gt_irq, wake_event, retry_flag, slow, tgl, busy_q;
  int n_done, n_irq, n_wake, n_rep, cycles, fail_count, check_count;
  int seed, i, k, j;

  cssc_ctrl dut (.clock(clock), .sys_rst(sys_rst), .cfg(cfg),
    .watch(watch), .channel_scan_mask(channel_scan_mask),
    .active_clk_khz(active_clk_khz), .busy_write(busy_write),
    .start_write(start_write), .flag_clear(flag_clear),
    .retry_clear(retry_clear), .wake_restart(wake_restart),
    .out_change_async(out_change_async), .conv_done(conv_done),
    .conv_value(conv_value), .conv_start(conv_start),
    .conv_repeat(conv_repeat), .channel_mux_select(mux),
    .conversion_busy_bit(busy), .threshold_compare_flag(cmp_flag),
    .conversion_done_flag(done_flag), .gt_irq(gt_irq),
    .wake_event(wake_event), .retry_event_flag(retry_flag),
    .result(result));

  cssc_conv_model conv (.clock(clock), .sys_rst(sys_rst),
    .conv_start(conv_start), .conv_repeat(conv_repeat), .slow(slow),
    .channel_mux_select(mux), .chan_val(vals), .conv_done(conv_done),
    .conv_value(conv_value));

  // 50 MHz, well above the pin watch minimum clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Event counters and result scoring at the end of each sequence
  always @(posedge clock) begin
    busy_q <= busy;
    n_done += int'(conv_done === 1'b1);
    n_irq  += int'(gt_irq === 1'b1);
    n_wake += int'(wake_event === 1'b1);
    n_rep  += int'(conv_repeat === 1'b1);
    if (busy_q === 1'b1 && busy === 1'b0) begin
      if (notes.size() == 0) chk(16'h1, 16'h0);
      else begin
        e = notes.pop_front();
        chk(result, e.res);
        chk({15'h0, done_flag}, 16'h1);
        chk({15'h0, cmp_flag}, {15'h0, e.flag});
        if (e.mchk) chk({10'h0, mux}, {10'h0, e.mux});
      end
    end
    cycles++;
    if (cycles == 30000) begin
      chk(16'h0, 16'h1);
      test_done();
    end
  end

  // Watched output activity while a conversion runs
  always @(posedge clock)
    out_change_async <= tgl ? ~out_change_async : 3'h0;

  // Starts one sequence; the end of busy takes the note back off
  task automatic run(logic [15:0] res, logic flag, logic [CH_W-1:0] m,
                     bit mchk, int convs, bit wake);
    int n0;
    int n;
    n0 = n_done;
    n  = 0;
    notes.push_back('{res, flag, m, mchk});
    if (wake) wake_restart <= 1'b1;
    else busy_write <= 1'b1;
    @(posedge clock);
    wake_restart <= 1'b0;
    busy_write   <= 1'b0;
    while (notes.size() != 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 4000) chk(16'h0, 16'h1);
    repeat (3) @(posedge clock);
    if (convs >= 0) chk(16'(n_done - n0), 16'(convs));
  endtask : run

  task automatic pulse_start();
    start_write <= 1'b1;
    @(posedge clock);
    start_write <= 1'b0;
  endtask : pulse_start

  initial begin
    seed = 32'h8f9c;
    {n_done, n_irq, n_wake, n_rep, cycles, fail_count, check_count} = '0;
    cfg = '0;
    watch = '0;
    channel_scan_mask = '0;
    active_clk_khz = 16'hc350;
    {busy_write, start_write, flag_clear, retry_clear} = 4'h0;
    {wake_restart, slow, tgl, busy_q} = 4'h0;
    out_change_async = 3'h0;
    sys_rst = 1'b1;
    for (i = 0; i < NCH; i++) vals[i] = 16'($random(seed)) & 16'h7fff;
    vals[0] = vals[0] | 16'h1;
    vals[3] = 16'hf000;
    vals[7] = 16'hf000;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    // Single conversions over accumulate codes 0 to 5
    cfg.greater_than_irq_enable <= 1'b1;
    for (i = 0; i < 6; i++) begin
      cfg.accumulate_count_select <= 3'(i);
      cfg.threshold <= vals[0] - 16'(i % 2);
      k = n_irq;
      run(vals[0], 1'(i % 2), 6'h0, 0, (i == 0) ? 1 : 2 << i, 0);
      chk(16'(n_irq - k), 16'(i % 2));
    end
    flag_clear <= 1'b1;
    @(posedge clock);
    flag_clear <= 1'b0;
    repeat (2) @(posedge clock);
    chk({15'h0, cmp_flag}, 16'h0);
    chk({15'h0, done_flag}, 16'h0);
    $display("test single done");
    // Mask scan set up in firmware order, then touch, resume, clean end
    // Start channel is the first enabled one, as firmware must set it
    cfg <= '{1'b1, CM_MASK_SCAN, 3'h0, 1'b1, 1'b0, 16'h8000, 6'h2, 6'h0};
    channel_scan_mask <= 64'h1084;
    pulse_start();
    k = n_wake;
    j = n_irq;
    run(16'hf000, 1'b1, 6'h07, 1, 2, 0);
    chk(16'(n_wake - k), 16'h1);
    chk(16'(n_irq - j), 16'h0);
    k = n_done;
    repeat (20) @(posedge clock);
    chk(16'(n_done - k), 16'h0);
    k = n_wake;
    run(vals[12], 1'b0, 6'h0, 0, 1, 0);
    chk(16'(n_wake - k), 16'h1);
    $display("test mask scan done");
    // Contiguous scan with four-sample averaging, wrap at the end
    cfg <= '{1'b0, CM_CONT_SCAN, 3'h1, 1'b0, 1'b1, 16'h8000, 6'h2, 6'h4};
    pulse_start();
    run(16'hf000, 1'b1, 6'h03, 1, 8, 0);
    run(16'hf000, 1'b1, 6'h03, 1, 12, 0);
    $display("test range scan done");
    // Retries capped at two, then at four, under constant output activity
    cfg.conversion_start_mode <= 3'h0;
    cfg.accumulate_count_select <= 3'h0;
    watch <= '{1'b0, 1'b0, 1'b1, RL_TWO};
    slow <= 1'b1;
    tgl <= 1'b1;
    k = n_rep;
    run(16'hf000, 1'b1, 6'h03, 1, -1, 0);
    chk(16'(n_rep - k), 16'(RL_TWO_N));
    watch.retry_limit_select <= 2'h2;
    k = n_rep;
    run(16'hf000, 1'b1, 6'h03, 1, -1, 0);
    chk(16'(n_rep - k), 16'(RL_FOUR_N));
    chk({15'h0, retry_flag}, 16'h1);
    tgl <= 1'b0;
    retry_clear <= 1'b1;
    @(posedge clock);
    retry_clear <= 1'b0;
    repeat (2) @(posedge clock);
    chk({15'h0, retry_flag}, 16'h0);
    $display("test pin watch done");
    // Wake with watch on and a slow active clock starts a conversion
    active_clk_khz <= 16'h03e8;
    slow <= 1'b0;
    run(16'hf000, 1'b1, 6'h03, 1, 1, 1);
    // Same wake with a fast active clock must leave the block stopped
    active_clk_khz <= 16'hc350;
    wake_restart <= 1'b1;
    k = n_done;
    @(posedge clock);
    wake_restart <= 1'b0;
    repeat (20) @(posedge clock);
    chk(16'(n_done - k), 16'h0);
    chk({15'h0, busy}, 16'h0);
    $display("test wake restart done");
    test_done();
  end
endmodule : cssc_ctrl_tb
`default_nettype wire
